//--- tda_pkg.sv
// constants, state codes and calendar helpers of the time/date adder
// assumes a 16-bit word register port and one 25 MHz clock
package tda_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int DW = 16;                 // word width
   localparam int AW = 5;                  // word address width

   // ---------------------------------------------------------------
   // register map (word addresses)
   // ---------------------------------------------------------------
   localparam logic [4:0] A_BASE = 5'h00;  // base_operand words 0..6
   localparam logic [4:0] A_ADD  = 5'h08;  // addend_operand words 0..2
   localparam logic [4:0] A_RES  = 5'h10;  // result_operand words 0..6
   localparam logic [4:0] A_CTRL = 5'h18;  // bit0 mode
   localparam logic [4:0] A_STAT = 5'h19;  // bit0 carry, bit1 error
   localparam logic [2:0] N_BASE = 3'h7;   // words in base and result
   localparam logic [2:0] N_ADD  = 3'h3;   // words in addend

   // ---------------------------------------------------------------
   // fields
   // ---------------------------------------------------------------
   localparam int CTRL_MODE = 0;
   localparam int ST_CARRY  = 0;
   localparam int ST_ERR    = 1;
   // mode 1 word positions
   localparam int I_YR = 0;
   localparam int I_MO = 1;
   localparam int I_DY = 2;
   localparam int I_DW = 3;
   localparam int I_HR = 4;
   localparam int I_MI = 5;
   localparam int I_SE = 6;
   // mode 0 and addend word positions
   localparam int J_HR = 0;
   localparam int J_MI = 1;
   localparam int J_SE = 2;

   // ---------------------------------------------------------------
   // limits and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] MAX_HR  = 16'h0017;  // 23
   localparam logic [15:0] MAX_MS  = 16'h003B;  // 59
   localparam logic [15:0] MAX_YR  = 16'h0063;  // 99
   localparam logic [15:0] MAX_MO  = 16'h000C;  // 12
   localparam logic [15:0] MAX_DY  = 16'h001F;  // 31
   localparam logic [15:0] ONE     = 16'h0001;
   localparam logic [15:0] MIN_60  = 16'h003C;  // 60
   localparam logic [16:0] HRS_DAY = 17'h00018; // 24
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam int          DOW_2000 = 6;       // 2000-01-01 is saturday
   localparam int          WEEK     = 7;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      TDA_IDLE = 2'b00,
      TDA_LOAD = 2'b01,
      TDA_STEP = 2'b11,
      TDA_FIN  = 2'b10
   } tda_state_e;

   // leap years: 2000..2099 all multiples of four are leap
   function automatic logic tda_leap(input logic [15:0] yr);
      tda_leap = (yr[1:0] == 2'b00);
   endfunction

   // days in month for year 2000+yr
   function automatic logic [15:0] tda_dim(input logic [15:0] yr,
                                           input logic [15:0] mo);
      unique case (mo)
         16'h0004, 16'h0006, 16'h0009, 16'h000B: tda_dim = 16'h001E;
         16'h0002: tda_dim = tda_leap(yr) ? 16'h001D : 16'h001C;
         default:  tda_dim = 16'h001F;
      endcase
   endfunction

endpackage

//--- tda_dow.sv
// day-of-week calculator for dates 2000-01-01 .. 2099-12-31
// assumes a valid year 0..99, month 1..12 and day 1..31 at its inputs
`timescale 1ns/10ps
module tda_dow (
   // date in
   input  wire logic [15:0] year_i,
   input  wire logic [15:0] month_i,
   input  wire logic [15:0] day_i,
   // weekday out, 0 sunday .. 6 saturday
   output logic      [15:0] dow_o
);

   int cum;
   int tot;

   // days before each month plus year and leap shifts, folded mod 7
   always_comb begin
      unique case (month_i)
         16'h0001: cum = 0;
         16'h0002: cum = 31;
         16'h0003: cum = 59;
         16'h0004: cum = 90;
         16'h0005: cum = 120;
         16'h0006: cum = 151;
         16'h0007: cum = 181;
         16'h0008: cum = 212;
         16'h0009: cum = 243;
         16'h000A: cum = 273;
         16'h000B: cum = 304;
         default:  cum = 334;
      endcase
      if (tda_pkg::tda_leap(year_i) && month_i > 16'h0002) begin
         cum = cum + 1;
      end
      tot = tda_pkg::DOW_2000 + int'(year_i[6:0])
          + (int'(year_i[6:0]) + 3) / 4 + cum + int'(day_i[4:0]) - 1;
      dow_o = 16'(tot % tda_pkg::WEEK);  // [RL14]
   end

endmodule

//--- tda_adder.sv
// time/date adder: base_operand + addend_operand -> result_operand
// assumes a single-cycle word register port and a level enable per scan
`timescale 1ns/10ps

// Overview of operation
// RL1: mode 0 uses three words hour, minute, second for all operands.
// RL2: mode 1 uses seven-word base and result, three-word addend.
// RL3: add repeats on every scan while enable is high; the code starts a new add each time it is back in idle.
// RL4: caller gives mode 0 hours 0..23, minutes and seconds 0..59.
// RL5: mode 0 sum past 23:59:59 wraps by 24 hours and sets carry.
// RL6: mode 0 field out of range sets error flag and indicator.
// RL7: mode 1 adds addend time to full date/time, writes seven words.
// RL8: mode 1 ignores the base day-of-week word.
// RL9: mode 1 uses true month lengths, leap februaries of 29 days.
// RL10: caller gives valid mode 1 base date and time fields.
// RL11: year 0..99 means 2000..2099 for leap and weekday.
// RL12: mode 1 addend hours 0..65535, minutes and seconds 0..59.
// RL13: mode 1 result weekday computed from result date into word three.
// RL14: weekday codes 0 sunday up to 6 saturday.
// RL15: mode 1 invalid base date or time sets error flag and indicator.
// RL16: mode 1 sum past 99-12-31 23:59:59 sets error flag.
// RL17: mode 1 hours of 24 or more become whole days added.
// RL18: each addition yields result words and carry flag.
// RL19: carry clears on an addition that does not wrap the day.
// RL20: an addition that errors leaves the result words unchanged.
module tda_adder (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        ce_i,
   // operation trigger
   input  wire logic        time_add_op_i,
   // register port
   input  wire logic [4:0]  addr_i,
   input  wire logic [15:0] wr_data_i,
   input  wire logic        wr_stb_i,
   input  wire logic        rd_stb_i,
   output logic      [15:0] rd_data_o,
   // flags
   output logic             carry_flag_o,
   output logic             exec_error_flag_o,
   output logic             err_led_o
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      tda_pkg::tda_state_e st;
      logic [6:0][15:0]    base;
      logic [2:0][15:0]    add;
      logic [6:0][15:0]    res;
      logic                mode;
      logic                carry;
      logic                err;
      logic                adv;     // a day was crossed
      logic [15:0]         wy;
      logic [15:0]         wmo;
      logic [15:0]         wd;
      logic [16:0]         wh;
      logic [15:0]         wmi;
      logic [15:0]         wse;
      logic [15:0]         rdata;
   } tda_state_s;

   tda_state_s  q;
   tda_state_s  n;
   logic [15:0] dow;
   logic [15:0] bh;
   logic [15:0] bm;
   logic [15:0] bs;
   logic [15:0] s_sum;
   logic [15:0] m_sum;
   logic        c_sec;
   logic        c_min;
   logic        bad;
   logic        at_end;

   // true when a word address falls in a window of cnt words
   function automatic logic in_win(input logic [4:0] a,
                                   input logic [4:0] base,
                                   input logic [2:0] cnt);
      in_win = (a >= base) && (a < base + 5'(cnt));
   endfunction

   // weekday of the working date
   tda_dow tda_dow_inst (
      .year_i  (q.wy),
      .month_i (q.wmo),
      .day_i   (q.wd),
      .dow_o   (dow)
   );

   // ---------------------------------------------------------------
   // operand decode and validity
   // ---------------------------------------------------------------
   // time words sit at 0..2 in mode 0, 4..6 in mode 1
   always_comb begin
      bh = q.mode ? q.base[tda_pkg::I_HR] : q.base[tda_pkg::J_HR]; // [RL1]
      bm = q.mode ? q.base[tda_pkg::I_MI] : q.base[tda_pkg::J_MI]; // [RL2]
      bs = q.mode ? q.base[tda_pkg::I_SE] : q.base[tda_pkg::J_SE];
      s_sum = bs + q.add[tda_pkg::J_SE];
      c_sec = (s_sum >= tda_pkg::MIN_60);
      m_sum = bm + q.add[tda_pkg::J_MI] + {15'h0000, c_sec};
      c_min = (m_sum >= tda_pkg::MIN_60);
      // time checks common to both modes
      bad = (bh > tda_pkg::MAX_HR) || (bm > tda_pkg::MAX_MS)
         || (bs > tda_pkg::MAX_MS)
         || (q.add[tda_pkg::J_MI] > tda_pkg::MAX_MS)
         || (q.add[tda_pkg::J_SE] > tda_pkg::MAX_MS);       // [RL6] [RL12]
      if (!q.mode) begin
         bad = bad || (q.add[tda_pkg::J_HR] > tda_pkg::MAX_HR); // [RL6]
      end else begin
         // date checks; the weekday word is not looked at
         bad = bad || (q.base[tda_pkg::I_YR] > tda_pkg::MAX_YR)
            || (q.base[tda_pkg::I_MO] == 16'h0000)
            || (q.base[tda_pkg::I_MO] > tda_pkg::MAX_MO)
            || (q.base[tda_pkg::I_DY] == 16'h0000)
            || (q.base[tda_pkg::I_DY] >
                tda_pkg::tda_dim(q.base[tda_pkg::I_YR],
                                 q.base[tda_pkg::I_MO]));  // [RL15] [RL8]
      end
      at_end = (q.wy == tda_pkg::MAX_YR) && (q.wmo == tda_pkg::MAX_MO)
            && (q.wd == tda_pkg::MAX_DY);
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      n = q;
      n.rdata = tda_pkg::WORD_RST;
      // register reads, data in the following cycle only
      if (rd_stb_i) begin
         if (in_win(addr_i, tda_pkg::A_BASE, tda_pkg::N_BASE)) begin
            n.rdata = q.base[addr_i[2:0]];
         end else if (in_win(addr_i, tda_pkg::A_ADD, tda_pkg::N_ADD)) begin
            n.rdata = q.add[addr_i[1:0]];
         end else if (in_win(addr_i, tda_pkg::A_RES, tda_pkg::N_BASE)) begin
            n.rdata = q.res[addr_i[2:0]];
         end else if (addr_i == tda_pkg::A_CTRL) begin
            n.rdata = {15'h0000, q.mode};
         end else if (addr_i == tda_pkg::A_STAT) begin
            n.rdata = {14'h0000, q.err, q.carry};
         end
      end
      // register writes; a write of 1 to error bit clears it
      if (wr_stb_i) begin
         if (in_win(addr_i, tda_pkg::A_BASE, tda_pkg::N_BASE)) begin
            n.base[addr_i[2:0]] = wr_data_i;
         end else if (in_win(addr_i, tda_pkg::A_ADD, tda_pkg::N_ADD)) begin
            n.add[addr_i[1:0]] = wr_data_i;
         end else if (addr_i == tda_pkg::A_CTRL) begin
            n.mode = wr_data_i[tda_pkg::CTRL_MODE];
         end else if (addr_i == tda_pkg::A_STAT &&
                      wr_data_i[tda_pkg::ST_ERR]) begin
            n.err = 1'b0;
         end
      end
      // operation sequence
      unique case (q.st)
         tda_pkg::TDA_IDLE: begin
            if (time_add_op_i) begin
               n.st = tda_pkg::TDA_LOAD;                      // [RL3]
            end
         end
         tda_pkg::TDA_LOAD: begin
            if (bad) begin
               n.err = 1'b1;                            // [RL6] [RL15]
               n.st  = tda_pkg::TDA_IDLE;                       // [RL20]
            end else begin
               n.wy  = q.base[tda_pkg::I_YR];
               n.wmo = q.base[tda_pkg::I_MO];
               n.wd  = q.base[tda_pkg::I_DY];
               n.wse = c_sec ? s_sum - tda_pkg::MIN_60 : s_sum;
               n.wmi = c_min ? m_sum - tda_pkg::MIN_60 : m_sum;
               n.wh  = {1'b0, bh} + {1'b0, q.add[tda_pkg::J_HR]}
                     + {16'h0000, c_min};
               n.adv = 1'b0;
               n.st  = tda_pkg::TDA_STEP;
            end
         end
         tda_pkg::TDA_STEP: begin
            // one day per cycle while 24 hours or more remain
            if (q.wh >= tda_pkg::HRS_DAY) begin
               if (q.mode && at_end) begin
                  n.err = 1'b1;                          // [RL16] [RL20]
                  n.st  = tda_pkg::TDA_IDLE;
               end else begin
                  n.wh  = q.wh - tda_pkg::HRS_DAY;       // [RL5] [RL17]
                  n.adv = 1'b1;
                  if (q.wd == tda_pkg::tda_dim(q.wy, q.wmo)) begin
                     n.wd = tda_pkg::ONE;                       // [RL9]
                     if (q.wmo == tda_pkg::MAX_MO) begin
                        n.wmo = tda_pkg::ONE;
                        n.wy  = q.wy + tda_pkg::ONE;           // [RL11]
                     end else begin
                        n.wmo = q.wmo + tda_pkg::ONE;
                     end
                  end else begin
                     n.wd = q.wd + tda_pkg::ONE;
                  end
               end
            end else begin
               n.st = tda_pkg::TDA_FIN;
            end
         end
         tda_pkg::TDA_FIN: begin
            // commit result words and carry
            if (q.mode) begin
               n.res[tda_pkg::I_YR] = q.wy;                     // [RL7]
               n.res[tda_pkg::I_MO] = q.wmo;
               n.res[tda_pkg::I_DY] = q.wd;
               n.res[tda_pkg::I_DW] = dow;                      // [RL13]
               n.res[tda_pkg::I_HR] = q.wh[15:0];
               n.res[tda_pkg::I_MI] = q.wmi;
               n.res[tda_pkg::I_SE] = q.wse;
            end else begin
               n.res[tda_pkg::J_HR] = q.wh[15:0];               // [RL1]
               n.res[tda_pkg::J_MI] = q.wmi;
               n.res[tda_pkg::J_SE] = q.wse;
            end
            n.carry = q.adv;                             // [RL18] [RL19]
            n.st    = tda_pkg::TDA_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         q <= '{st: tda_pkg::TDA_IDLE, default: '0};
      end else if (ce_i) begin
         q <= n;
      end
   end

   // outputs straight from flops
   assign rd_data_o         = q.rdata;
   assign carry_flag_o      = q.carry;
   assign exec_error_flag_o = q.err;
   assign err_led_o         = q.err;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_scan_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_IDLE && time_add_op_i
      |=> q.st == tda_pkg::TDA_LOAD)                                // [RL3]
      else $error("enable did not start an addition");

   a_mode0_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_FIN && !q.mode
      |=> q.res[tda_pkg::J_HR] <= tda_pkg::MAX_HR
          && q.carry == $past(q.adv))                               // [RL5]
      else $error("mode 0 result hour or carry wrong");

   a_dow_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      q.res[tda_pkg::I_DW] <= 16'h0006)                            // [RL14]
      else $error("weekday code above six");

   a_err_res_kept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st != tda_pkg::TDA_IDLE && !q.err ##1 q.err
      |-> $stable(q.res))                                          // [RL20]
      else $error("result changed on an error");

   a_carry_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_FIN && !q.adv |=> !q.carry)     // [RL19]
      else $error("carry left set without wrap");

   a_mode1_month: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_FIN && q.mode
      |=> q.res[tda_pkg::I_DY] <= tda_pkg::tda_dim(q.res[tda_pkg::I_YR],
                                               q.res[tda_pkg::I_MO])
          && q.res[tda_pkg::I_HR] <= tda_pkg::MAX_HR)               // [RL9]
      else $error("mode 1 day or hour out of range");

   a_bad_base_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_LOAD && bad
      |=> q.err && q.st == tda_pkg::TDA_IDLE)                 // [RL6] [RL15]
      else $error("invalid operand not flagged");

   a_end_overflow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_STEP && q.mode && at_end
      && q.wh >= tda_pkg::HRS_DAY |=> q.err)                       // [RL16]
      else $error("calendar overflow not flagged");

   a_day_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_STEP && q.wh >= tda_pkg::HRS_DAY
      && !(q.mode && at_end)
      |=> q.wh == $past(q.wh) - tda_pkg::HRS_DAY && q.adv)         // [RL17]
      else $error("hours not reduced by one day");

   a_dow_written: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_FIN && q.mode
      |=> q.res[tda_pkg::I_DW] == $past(dow))                      // [RL13]
      else $error("weekday word not written");

   // ---------------------------------------------------------------
   // read port, sticky flag, freeze, range and idle-wait checks
   // ---------------------------------------------------------------
   a_res_frozen: assert property (                                 // [RL20]
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st != tda_pkg::TDA_FIN |=> $stable(q.res))
      else $error("result changed outside commit");

   a_carry_frozen: assert property (                               // [RL19]
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st != tda_pkg::TDA_FIN |=> $stable(q.carry))
      else $error("carry changed outside commit");

   a_err_sticky: assert property (                                  // [RL6]
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.err && !(wr_stb_i && addr_i == tda_pkg::A_STAT
      && wr_data_i[tda_pkg::ST_ERR]) |=> q.err)
      else $error("error flag dropped without a clear");

   a_rdata_idle: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && !rd_stb_i |=> q.rdata == tda_pkg::WORD_RST)
      else $error("read data stood past its cycle");

   a_time_norm: assert property (                                   // [RL7]
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_LOAD && !bad
      |=> q.wmi <= tda_pkg::MAX_MS && q.wse <= tda_pkg::MAX_MS)
      else $error("minute or second not normalised");

   a_year_range: assert property (                                 // [RL16]
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_FIN && q.mode
      |=> q.res[tda_pkg::I_YR] <= tda_pkg::MAX_YR)
      else $error("result year beyond range");

   a_idle_wait: assert property (                                   // [RL3]
      @(posedge clk_i) disable iff (sys_rst_i)
      ce_i && q.st == tda_pkg::TDA_IDLE && !time_add_op_i
      |=> q.st == tda_pkg::TDA_IDLE)
      else $error("addition began without enable");

endmodule

//--- tda_seq.sv
// sequencer model that drives the adder's enable once per scan
// assumes the bench moves fire_i and hold_i just after a rising edge
`timescale 1ns/10ps
module tda_seq (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   // requests from the bench
   input  wire logic fire_i,
   input  wire logic hold_i,
   // enable towards the adder
   output logic      time_add_op_o
);
   logic fire_reg;
   logic pulse_reg;

   // rising_edge_pulse: one scan high for each request edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fire_reg  <= 1'b0;
         pulse_reg <= 1'b0;
      end else begin
         fire_reg  <= fire_i;
         pulse_reg <= fire_i & ~fire_reg;
      end
   end

   // a held level starts a new addition each time the adder is back in idle
   assign time_add_op_o = pulse_reg | hold_i;
endmodule

//--- tda_adder_tb_top.sv
// bench for the time/date adder: bus tasks, sequencer model, checks
// assumes the register map and flag layout of tda_pkg, one clock
`timescale 1ns/10ps
module tda_adder_tb_top;
   localparam int SETTLE = 16;   // above the short-case latency
   localparam int LIMIT  = 9000; // cycle ceiling of the whole run
   localparam logic [4:0] BAS = tda_pkg::A_BASE;
   localparam logic [4:0] ADD = tda_pkg::A_ADD;
   localparam logic [4:0] RES = tda_pkg::A_RES;
   localparam logic [4:0] STA = tda_pkg::A_STAT;
   localparam logic [4:0] CTL = tda_pkg::A_CTRL;
   localparam logic [0:6][15:0] R1 = {16'h000A, 16'h0006, 16'h000F,
      16'h0002, 16'h000B, 16'h0002, 16'h0003};
   logic        clk_i;
   logic        sys_rst_i;
   logic        ce;
   logic        fire;
   logic        hold;
   logic        op;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [15:0] rd_data_o;
   logic        carry_flag_o;
   logic        exec_error_flag_o;
   logic        err_led_o;
   int          bad_count;
   int          total_checks;
   int          cyc;

   tda_seq tda_seq_inst (
      .clk_i         (clk_i),
      .sys_rst_i     (sys_rst_i),
      .fire_i        (fire),
      .hold_i        (hold),
      .time_add_op_o (op)
   );

   tda_adder tda_adder_inst (
      .clk_i             (clk_i),
      .sys_rst_i         (sys_rst_i),
      .ce_i              (ce),
      .time_add_op_i     (op),
      .addr_i            (addr),
      .wr_data_i         (wdata),
      .wr_stb_i          (wr_stb),
      .rd_stb_i          (rd_stb),
      .rd_data_o         (rd_data_o),
      .carry_flag_o      (carry_flag_o),
      .exec_error_flag_o (exec_error_flag_o),
      .err_led_o         (err_led_o)
   );

   // 25 MHz clock
   initial clk_i = 1'b0;
   always #20 clk_i = ~clk_i;

   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write strobe beside address and data
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clk_i);
      wr_stb <= 1'b0;
   endtask

   // one-cycle read strobe, data checked in the following cycle
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clk_i);
      rd_stb <= 1'b0;
      #1;
      chk(rd_data_o, exp);
   endtask

   // load operands, fire one addition, check words and flags
   task automatic run(input int n, input logic [0:6][15:0] b,
                      input logic [0:2][15:0] a,
                      input logic [0:6][15:0] r,
                      input logic c, input logic e);
      for (int i = 0; i < n; i++) wr(BAS + 5'(i), b[i]);
      for (int i = 0; i < 3; i++) wr(ADD + 5'(i), a[i]);
      @(posedge clk_i) fire <= 1'b1;
      @(posedge clk_i) fire <= 1'b0;
      repeat (SETTLE + int'(a[0]) / 24) @(posedge clk_i);
      #1;
      chk({15'h0, carry_flag_o}, {15'h0, c});
      chk({14'h0, err_led_o, exec_error_flag_o}, {14'h0, e, e});
      for (int i = 0; i < n; i++) rd(RES + 5'(i), r[i]);
      rd(STA, {14'h0, e, c});
      if (e) wr(STA, 16'h0002);
   endtask

   // hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         test_done();
      end
   end

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      sys_rst_i = 1'b1;
      ce = 1'b1;
      fire = 1'b0;
      hold = 1'b0;
      addr = 5'h00;
      wdata = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      bad_count = 0;
      total_checks = 0;
      cyc = 0;
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // reset values and an unmapped place
      rd(STA, 16'h0000);
      @(posedge clk_i) #1 chk(rd_data_o, 16'h0000); // data gone again
      rd(RES, 16'h0000);
      rd(CTL, 16'h0000);
      rd(5'h1F, 16'h0000);
      // mode 0: plain, wrap, end-of-day, errors, boundary
      run(3, {16'h000A, 16'h0014, 16'h001E, 64'h0},
          {16'h0001, 16'h002D, 16'h0028},
          {16'h000C, 16'h0006, 16'h000A, 64'h0}, 1'b0, 1'b0);
      run(3, {16'h000A, 16'h0000, 16'h0000, 64'h0},
          {16'h000F, 16'h0000, 16'h0000},
          {16'h0001, 16'h0000, 16'h0000, 64'h0}, 1'b1, 1'b0);
      run(3, {16'h0017, 16'h003B, 16'h003B, 64'h0},
          {16'h0000, 16'h0000, 16'h0001}, 112'h0, 1'b1, 1'b0);
      run(3, {16'h0017, 16'h003C, 16'h0000, 64'h0},
          48'h0, 112'h0, 1'b1, 1'b1);
      run(3, {16'h0001, 16'h0000, 16'h0000, 64'h0},
          {16'h0018, 16'h0000, 16'h0000}, 112'h0, 1'b1, 1'b1);
      run(3, {16'h0017, 16'h003B, 16'h003B, 64'h0},
          48'h0, {16'h0017, 16'h003B, 16'h003B, 64'h0}, 1'b0, 1'b0);
      // held enable keeps adding with a changed addend
      @(posedge clk_i) hold <= 1'b1;
      wr(ADD + 5'h02, 16'h0001);
      repeat (SETTLE) @(posedge clk_i);
      rd(RES + 5'h02, 16'h0000);
      chk({15'h0, carry_flag_o}, 16'h0001);
      @(posedge clk_i) hold <= 1'b0;
      repeat (SETTLE) @(posedge clk_i);
      // frozen clock enable takes no write; results are read-only
      ce <= 1'b0;
      wr(ADD + 5'h02, 16'h0009);
      ce <= 1'b1;
      rd(ADD + 5'h02, 16'h0001);
      wr(RES, 16'h0055);
      rd(RES, 16'h0000);
      rd(BAS + 5'h01, 16'h003B);
      wr(STA, 16'h0001);
      rd(STA, 16'h0001);
      // mode 1: leap day, month end, long addend, plain, errors
      wr(CTL, 16'h0001);
      rd(CTL, 16'h0001);
      run(7, {16'h0018, 16'h0002, 16'h001C, 16'h0007,
              16'h0017, 16'h0000, 16'h0000}, {16'h0001, 32'h0},
          {16'h0018, 16'h0002, 16'h001D, 16'h0004, 48'h0}, 1'b1, 1'b0);
      run(7, {16'h0017, 16'h0002, 16'h001C, 16'h0000,
              16'h0017, 16'h001E, 16'h0000},
          {16'h0000, 16'h001E, 16'h0000},
          {16'h0017, 16'h0003, 16'h0001, 16'h0003, 48'h0}, 1'b1, 1'b0);
      run(7, {16'h0000, 16'h0001, 16'h0001, 16'h0006,
              48'h0}, {16'h0031, 32'h0},
          {16'h0000, 16'h0001, 16'h0003, 16'h0001, 16'h0001, 32'h0},
          1'b1, 1'b0);
      run(7, {16'h0000, 16'h0001, 16'h0001, 16'h0000,
              48'h0}, {16'hFFFF, 32'h0},
          {16'h0007, 16'h0006, 16'h0017, 16'h0006, 16'h000F, 32'h0},
          1'b1, 1'b0);
      run(7, {16'h000A, 16'h0006, 16'h000F, 16'h0000,
              16'h000A, 32'h0}, {16'h0001, 16'h0002, 16'h0003},
          R1, 1'b0, 1'b0);
      run(7, {16'h0063, 16'h000C, 16'h001F, 16'h0000,
              16'h0017, 16'h003B, 16'h003B}, {32'h0, 16'h0001},
          R1, 1'b0, 1'b1);
      run(7, {16'h0005, 16'h000D, 16'h0001, 64'h0},
          48'h0, R1, 1'b0, 1'b1);
      // reset after the last run returns mode and results to zero
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(CTL, 16'h0000);
      rd(RES + 5'h04, 16'h0000);
      test_done();
   end
endmodule
